// *** core/aspt_pkg.sv ***
`default_nettype none
package aspt_pkg;
  // ********************
  // Register offsets
  // ********************
  localparam logic [7:0] OFF_PSC = 8'h09;
  localparam logic [7:0] OFF_ACTL = 8'h0a;
  localparam logic [7:0] OFF_ADAT = 8'h0b;
  localparam logic [7:0] OFF_C1 = 8'h13;
  localparam logic [7:0] OFF_C2 = 8'h14;
  localparam logic [7:0] OFF_C3 = 8'h15;
  localparam logic [7:0] OFF_S1 = 8'h16;
  localparam logic [7:0] OFF_S2 = 8'h17;
  localparam logic [7:0] OFF_DB = 8'h18;
  localparam logic [7:0] OFF_BR = 8'h19;
  localparam logic [7:0] OFF_IST = 8'h1a;
  localparam logic [7:0] OFF_IMSK = 8'h1b;
  localparam logic [7:0] OFF_CFG = 8'h1e;
  // ********************
  // Fields and reset values
  // ********************
  localparam int C1_ENABLE = 6;
  localparam int C1_TX_INVERT = 5;
  localparam int C1_NINE = 4;
  localparam int C2_TXIE = 7;
  localparam int C2_TXEN = 3;
  localparam int C2_RXEN = 2;
  localparam int CFG_SRC = 0;
  localparam logic [7:0] C3_WMASK = 8'h4f;
  localparam logic [7:0] BR_WMASK = 8'hf7;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h01;
  localparam int IRQ_W = 6;
  // Event bits: tx empty, tx done, rx full, overrun, framing, break.
  localparam int EV_TXE = 0;
  localparam int EV_TXC = 1;
  localparam int EV_RXF = 2;
  localparam int EV_OVR = 3;
  localparam int EV_FRM = 4;
  localparam int EV_BRK = 5;
  localparam logic [3:0] RT_LAST = 4'hf;
  localparam logic [3:0] RT_MID = 4'h7;
  localparam logic [3:0] BITS_8 = 4'ha;
  localparam logic [3:0] BITS_9 = 4'hb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } aspt_req_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_PRE = 2'b01, TX_SHIFT = 2'b10} aspt_tx_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} aspt_rx_t;
endpackage : aspt_pkg
`default_nettype wire

// *** core/aspt_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module aspt_top (
  input wire logic clk,
  input wire logic rstn,
  input wire aspt_pkg::aspt_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic irq,
  input wire logic xtal_tick,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe
);
  // ********************
  // Register file
  // ********************
  logic [7:0] psc_q, psc_d, actl_q, actl_d, c1_q, c1_d, c2_q, c2_d, c3_q, c3_d;
  logic [7:0] br_q, br_d, cfg_q, cfg_d, rdata_q, rdata_d;
  logic [aspt_pkg::IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d, ev;
  logic [1:0] ev_tx;
  logic [aspt_pkg::IRQ_W-1:2] ev_rx;
  logic wr_db, rd_db;
  logic tx_empty_flag_q, tx_empty_flag_d, tc_q, tc_d;
  logic rf_q, rf_d, ovr_q, ovr_d, fe_q, fe_d, bkf_q, bkf_d, rpf_q, rpf_d, r8_q, r8_d;
  logic [7:0] rxbuf_q, rxbuf_d;

  assign wr_db = bus_req.wr && bus_req.addr == aspt_pkg::OFF_DB;
  assign rd_db = bus_req.rd && bus_req.addr == aspt_pkg::OFF_DB;

  always_comb begin
    {psc_d, actl_d, c1_d, c2_d, c3_d, br_d, cfg_d, imsk_d} = {psc_q, actl_q, c1_q,
      c2_q, c3_q, br_q, cfg_q, imsk_q};
    rdata_d = 8'h00;
    // A fresh event beats a clear written in the same cycle.
    ist_d = ist_q;
    if (bus_req.wr) begin
      case (bus_req.addr)
        aspt_pkg::OFF_PSC: psc_d = bus_req.wdata;
        aspt_pkg::OFF_ACTL: actl_d = bus_req.wdata;
        aspt_pkg::OFF_C1: c1_d = bus_req.wdata;
        aspt_pkg::OFF_C2: c2_d = bus_req.wdata;
        aspt_pkg::OFF_C3: c3_d = bus_req.wdata & aspt_pkg::C3_WMASK;
        aspt_pkg::OFF_BR: br_d = bus_req.wdata & aspt_pkg::BR_WMASK;
        aspt_pkg::OFF_CFG: cfg_d = {7'h00, bus_req.wdata[aspt_pkg::CFG_SRC]};
        aspt_pkg::OFF_IMSK: imsk_d = bus_req.wdata[aspt_pkg::IRQ_W-1:0];
        aspt_pkg::OFF_IST: ist_d = ist_q & ~bus_req.wdata[aspt_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    ist_d = ist_d | ev;
    if (bus_req.rd) begin
      case (bus_req.addr)
        aspt_pkg::OFF_PSC: rdata_d = psc_q;
        aspt_pkg::OFF_ACTL: rdata_d = actl_q;
        aspt_pkg::OFF_ADAT: rdata_d = 8'h00;
        aspt_pkg::OFF_C1: rdata_d = c1_q;
        aspt_pkg::OFF_C2: rdata_d = c2_q;
        aspt_pkg::OFF_C3: rdata_d = {r8_q, c3_q[6:0]};
        aspt_pkg::OFF_S1: rdata_d = {tx_empty_flag_q, tc_q, rf_q, 1'b0, ovr_q, 1'b0, fe_q, 1'b0};
        aspt_pkg::OFF_S2: rdata_d = {6'h00, bkf_q, rpf_q};
        aspt_pkg::OFF_DB: rdata_d = rxbuf_q;
        aspt_pkg::OFF_BR: rdata_d = br_q;
        aspt_pkg::OFF_IST: rdata_d = {2'b00, ist_q};
        aspt_pkg::OFF_IMSK: rdata_d = {2'b00, imsk_q};
        aspt_pkg::OFF_CFG: rdata_d = cfg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {psc_q, actl_q, c1_q, c2_q, c3_q, br_q, rdata_q} <= {7{aspt_pkg::RST_REG}};
      cfg_q <= aspt_pkg::RST_CFG;
      {imsk_q, ist_q} <= '0;
    end else begin
      {psc_q, actl_q, c1_q, c2_q, c3_q, br_q, rdata_q} <= {psc_d, actl_d, c1_d, c2_d,
        c3_d, br_d, rdata_d};
      {cfg_q, imsk_q, ist_q} <= {cfg_d, imsk_d, ist_d};
    end
  end

  assign bus_rdata = rdata_q;
  assign ev = {ev_rx, ev_tx};
  assign irq = (|(ist_q & imsk_q)) || (tx_empty_flag_q && c2_q[aspt_pkg::C2_TXIE]);

  // ********************
  // Shared baud generator
  // ********************
  logic [7:0] div_q, div_d;
  logic rt_tick_q, rt_tick_d, src_tick, ena;
  assign ena = c1_q[aspt_pkg::C1_ENABLE];
  assign src_tick = cfg_q[aspt_pkg::CFG_SRC] ? 1'b1 : xtal_tick;

  always_comb begin
    div_d = div_q;
    rt_tick_d = 1'b0;
    if (!ena) begin
      div_d = 8'h00;
    end else if (src_tick) begin
      if (div_q >= psc_q) begin
        div_d = 8'h00;
        rt_tick_d = 1'b1;
      end else begin
        div_d = div_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {div_q, rt_tick_q} <= '0;
    end else begin
      {div_q, rt_tick_q} <= {div_d, rt_tick_d};
    end
  end

  // ********************
  // Transmitter
  // ********************
  aspt_pkg::aspt_tx_t tx_st_q, tx_st_d;
  logic [10:0] sh_q, sh_d;
  logic [3:0] nbits_q, nbits_d, trt_q, trt_d, flen;
  logic [7:0] tbuf_q, tbuf_d;
  logic te_q, te_d, txd_q, txd_d, tx_en, bit_end, load;
  assign tx_en = ena && c2_q[aspt_pkg::C2_TXEN];
  assign flen = c1_q[aspt_pkg::C1_NINE] ? aspt_pkg::BITS_9 : aspt_pkg::BITS_8;

  always_comb begin
    tx_st_d = tx_st_q;
    {sh_d, nbits_d, trt_d, tbuf_d, tx_empty_flag_d, tc_d} = {sh_q, nbits_q, trt_q, tbuf_q, tx_empty_flag_q, tc_q};
    te_d = tx_en;
    load = 1'b0;
    ev_tx = 2'b00;
    bit_end = 1'b0;
    if (tx_st_q != aspt_pkg::TX_IDLE && rt_tick_q) begin
      trt_d = trt_q + 4'h1;
      bit_end = trt_q == aspt_pkg::RT_LAST;
    end
    case (tx_st_q)
      aspt_pkg::TX_IDLE: begin
        trt_d = 4'h0;
        if (tx_en && !te_q) begin
          sh_d = '1;
          nbits_d = flen;
          tc_d = 1'b0;
          tx_st_d = aspt_pkg::TX_PRE;
        end else if (tx_en && !tx_empty_flag_q) begin
          load = 1'b1;
        end
      end
      aspt_pkg::TX_PRE, aspt_pkg::TX_SHIFT: begin
        if (bit_end) begin
          sh_d = {1'b1, sh_q[10:1]};
          nbits_d = nbits_q - 4'h1;
          if (nbits_q == 4'h1) begin
            if (tx_en && !tx_empty_flag_q) begin
              load = 1'b1;
            end else begin
              tx_st_d = aspt_pkg::TX_IDLE;
              tc_d = 1'b1;
              ev_tx[aspt_pkg::EV_TXC] = 1'b1;
            end
          end
        end
      end
      default: tx_st_d = aspt_pkg::TX_IDLE;
    endcase
    if (load) begin
      // Stop 1 at the top, start 0 at the bottom; the ninth bit rides below stop.
      sh_d = {2'b11, tbuf_q, 1'b0};
      if (c1_q[aspt_pkg::C1_NINE]) begin
        sh_d[9] = c3_q[6];
      end
      nbits_d = flen;
      tx_empty_flag_d = 1'b1;
      ev_tx[aspt_pkg::EV_TXE] = 1'b1;
      tx_st_d = aspt_pkg::TX_SHIFT;
    end
    if (wr_db) begin
      tbuf_d = bus_req.wdata;
      tx_empty_flag_d = 1'b0;
      tc_d = 1'b0;
    end
    if (!ena) begin
      tx_st_d = aspt_pkg::TX_IDLE;
    end
    // Idle is a mark; inversion applies to every level driven.
    txd_d = (tx_st_d == aspt_pkg::TX_IDLE ? 1'b1 : sh_d[0]) ^ c1_q[aspt_pkg::C1_TX_INVERT];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_st_q <= aspt_pkg::TX_IDLE;
      {sh_q, nbits_q, trt_q, tbuf_q, te_q} <= {11'h7ff, 4'h0, 4'h0, 8'h00, 1'b0};
      {tx_empty_flag_q, tc_q, txd_q} <= 3'b111;
    end else begin
      tx_st_q <= tx_st_d;
      {sh_q, nbits_q, trt_q, tbuf_q, te_q} <= {sh_d, nbits_d, trt_d, tbuf_d, te_d};
      {tx_empty_flag_q, tc_q, txd_q} <= {tx_empty_flag_d, tc_d, txd_d};
    end
  end

  // ********************
  // Receiver
  // ********************
  aspt_pkg::aspt_rx_t rx_st_q, rx_st_d;
  logic [3:0] rrt_q, rrt_d, rcnt_q, rcnt_d;
  logic [9:0] rsh_q, rsh_d;
  logic rxd, rx_en;
  assign rxd = pin_i[1];
  assign rx_en = ena && c2_q[aspt_pkg::C2_RXEN];

  always_comb begin
    rx_st_d = rx_st_q;
    {rrt_d, rcnt_d, rsh_d, rxbuf_d} = {rrt_q, rcnt_q, rsh_q, rxbuf_q};
    {rf_d, ovr_d, fe_d, bkf_d, rpf_d, r8_d} = {rf_q, ovr_q, fe_q, bkf_q, rpf_q, r8_q};
    ev_rx = '0;
    // Flags drop on a data read; a character ending in the same cycle sets them again.
    if (rd_db) begin
      rf_d = 1'b0;
      ovr_d = 1'b0;
      fe_d = 1'b0;
      bkf_d = 1'b0;
    end
    case (rx_st_q)
      aspt_pkg::RX_IDLE: begin
        if (rx_en && rt_tick_q && !rxd) begin
          rx_st_d = aspt_pkg::RX_START;
          rrt_d = 4'h0;
          rpf_d = 1'b1;
        end
      end
      aspt_pkg::RX_START: begin
        if (rt_tick_q) begin
          rrt_d = rrt_q + 4'h1;
          if (rrt_q == aspt_pkg::RT_MID) begin
            rrt_d = 4'h0;
            rcnt_d = 4'h0;
            rx_st_d = rxd ? aspt_pkg::RX_IDLE : aspt_pkg::RX_DATA;
            rpf_d = !rxd;
          end
        end
      end
      aspt_pkg::RX_DATA: begin
        if (rt_tick_q) begin
          rrt_d = rrt_q + 4'h1;
          if (rrt_q == aspt_pkg::RT_LAST) begin
            rsh_d = {rxd, rsh_q[9:1]};
            rcnt_d = rcnt_q + 4'h1;
            if (rcnt_q + 4'h2 == flen) begin
              rx_st_d = aspt_pkg::RX_IDLE;
              rpf_d = 1'b0;
              if (!rxd) begin
                fe_d = 1'b1;
                ev_rx[aspt_pkg::EV_FRM] = 1'b1;
              end
              // In 8-bit mode bit 0 still holds the last frame's stop, so it is left out.
              if ((c1_q[aspt_pkg::C1_NINE] ? rsh_d : {rsh_d[9:1], 1'b0}) == 10'h000) begin
                bkf_d = 1'b1;
                ev_rx[aspt_pkg::EV_BRK] = 1'b1;
              end
              if (rf_q && !rd_db) begin
                ovr_d = 1'b1;
                ev_rx[aspt_pkg::EV_OVR] = 1'b1;
              end else begin
                rxbuf_d = c1_q[aspt_pkg::C1_NINE] ? rsh_d[7:0] : rsh_d[8:1];
                r8_d = rsh_d[8];
                rf_d = 1'b1;
                ev_rx[aspt_pkg::EV_RXF] = 1'b1;
              end
            end
          end
        end
      end
      default: rx_st_d = aspt_pkg::RX_IDLE;
    endcase
    if (!rx_en) begin
      rx_st_d = aspt_pkg::RX_IDLE;
      rpf_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_st_q <= aspt_pkg::RX_IDLE;
      {rrt_q, rcnt_q, rsh_q, rxbuf_q} <= '0;
      {rf_q, ovr_q, fe_q, bkf_q, rpf_q, r8_q} <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      {rrt_q, rcnt_q, rsh_q, rxbuf_q} <= {rrt_d, rcnt_d, rsh_d, rxbuf_d};
      {rf_q, ovr_q, fe_q, bkf_q, rpf_q, r8_q} <= {rf_d, ovr_d, fe_d, bkf_d, rpf_d, r8_d};
    end
  end

  // ********************
  // Port E pin sharing
  // ********************
  // While the port is enabled it owns both pins; bit 1 becomes a pure input.
  assign pin_o = ena ? {gpio_out[1], txd_q} : gpio_out;
  assign pin_oe = ena ? 2'b01 : gpio_oe;
endmodule : aspt_top
`default_nettype wire

// *** bench/aspt_top_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module aspt_props (
  input wire logic clk,
  input wire logic rstn,
  input wire aspt_pkg::aspt_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic irq,
  input wire logic xtal_tick,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  input wire logic [1:0] pin_i,
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its slot");
  a_stat_two: assert property (bus_req.rd && bus_req.addr == aspt_pkg::OFF_S2
    |=> bus_rdata[7:2] == 6'h00) else $error("status two upper bits set");
  a_stat_one: assert property (bus_req.rd && bus_req.addr == aspt_pkg::OFF_S1
    |=> !bus_rdata[4] && !bus_rdata[2] && !bus_rdata[0]) else $error("status one spare bit set");
  a_unmapped_zero: assert property (bus_req.rd && (bus_req.addr == 8'h20
    || bus_req.addr == aspt_pkg::OFF_ADAT) |=> bus_rdata == 8'h00) else $error("empty place read");
  a_ctl_three: assert property (bus_req.rd && bus_req.addr == aspt_pkg::OFF_C3
    |=> bus_rdata[5:4] == 2'b00) else $error("reserved control bits set");
  a_cfg_bits: assert property (bus_req.rd && bus_req.addr == aspt_pkg::OFF_CFG
    |=> bus_rdata[7:1] == 7'h00) else $error("config spare bits set");
  a_pin_share: assert property (pin_oe == 2'b01 || (pin_oe == gpio_oe && pin_o == gpio_out))
    else $error("pin ownership wrong");
  a_bit_hold: assert property ($changed(pin_o[0]) && $stable(pin_oe) && pin_oe == 2'b01
    |=> $stable(pin_o[0]) [*8]) else $error("serial bit too short");
  a_irq_reset: assert property ($rose(rstn) |-> !irq) else $error("interrupt after reset");
  cover property (bus_req.wr && bus_req.addr == aspt_pkg::OFF_DB);
  cover property ($rose(irq));
  cover property (pin_oe == 2'b01 && pin_o[0] == 1'b0);
endmodule : aspt_props
bind aspt_top aspt_props aspt_props_i (.clk(clk), .rstn(rstn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .irq(irq), .xtal_tick(xtal_tick), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
`default_nettype wire

// *** bench/aspt_remote.sv ***
`timescale 1ns/100ps
`default_nettype none
module aspt_remote (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic inv,
  input wire logic nine,
  input wire logic slow,
  output logic rx_line
);
  // ****
  // Far station
  // ****
  // A start must still be low at mid-bit, so a polarity change is not taken as a frame.
  logic [8:0] got[$];
  logic [8:0] d;
  int bad_stop = 0;
  int bl;
  initial rx_line = 1'b1;
  initial forever begin
    @(posedge clk);
    bl = slow ? 32 : 16;
    if ((tx_line ^ inv) === 1'b0) begin
      repeat (bl / 2) @(posedge clk);
      if ((tx_line ^ inv) === 1'b0) begin
        d = 9'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (bl) @(posedge clk);
          d[i] = tx_line ^ inv;
        end
        repeat (bl) @(posedge clk);
        if ((tx_line ^ inv) !== 1'b1) bad_stop++;
        got.push_back(d);
      end
    end
  end
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_line <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask : send
endmodule : aspt_remote
`default_nettype wire

// *** bench/tb_aspt_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_aspt_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  aspt_pkg::aspt_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic irq;
  logic xtal_tick = 1'b0;
  logic [1:0] gpio_out = 2'b11;
  logic [1:0] gpio_oe = 2'b10;
  logic [1:0] pin_o;
  logic [1:0] pin_oe;
  logic rx_line;
  logic inv = 1'b0;
  logic nine = 1'b0;
  logic slow = 1'b0;
  logic [7:0] v;
  logic [7:0] ra[8] = '{8'h16, 8'h17, 8'h1e, 8'h13, 8'h14, 8'h09, 8'h19, 8'h15};
  logic [7:0] re[8] = '{8'hc0, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ma[8] = '{8'h15, 8'h19, 8'h1e, 8'h16, 8'h17, 8'h0b, 8'h20, 8'h09};
  logic [7:0] me[8] = '{8'h4f, 8'hf7, 8'h01, 8'hc0, 8'h00, 8'h00, 8'h00, 8'hff};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) xtal_tick <= ~xtal_tick;
  aspt_top aspt_top_i (.clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .irq(irq), .xtal_tick(xtal_tick), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_i({rx_line, pin_o[0]}), .pin_o(pin_o), .pin_oe(pin_oe));
  aspt_remote aspt_remote_i (.clk(clk), .tx_line(pin_o[0]), .inv(inv), .nine(nine),
    .slow(slow), .rx_line(rx_line));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    v = 8'h00;
    for (int i = 0; i < 500 && (v & m) == 8'h00; i++) rd(a);
  endtask : poll
  task automatic wait_got(input int n);
    for (int i = 0; i < 3000 && aspt_remote_i.got.size() < n; i++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask : wait_got
  task automatic finish_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(v, re[i])
    end
    $display("test reset values done");
    foreach (ma[i]) begin
      wr(ma[i], 8'hff);
      rd(ma[i]);
      `CHK(v, me[i])
    end
    wr(aspt_pkg::OFF_PSC, 8'h00);
    wr(aspt_pkg::OFF_C3, 8'h00);
    $display("test access kinds done");
    // ****
    // Transmit
    // ****
    wr(aspt_pkg::OFF_CFG, 8'h00);
    slow <= 1'b1;
    wr(aspt_pkg::OFF_C1, 8'h40);
    `CHK(pin_oe, 2'b01)
    wr(aspt_pkg::OFF_C2, 8'h08);
    wr(aspt_pkg::OFF_DB, 8'ha5);
    rd(aspt_pkg::OFF_S1);
    `CHK(v[7], 1'b0)
    wait_got(1);
    `CHK(aspt_remote_i.got[0], 9'h0a5)
    wr(aspt_pkg::OFF_CFG, 8'h01);
    slow <= 1'b0;
    wr(aspt_pkg::OFF_C2, 8'h00);
    wr(aspt_pkg::OFF_C3, 8'h40);
    wr(aspt_pkg::OFF_C1, 8'h70);
    inv <= 1'b1;
    nine <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(pin_o[0], 1'b0)
    wr(aspt_pkg::OFF_C2, 8'h08);
    wr(aspt_pkg::OFF_DB, 8'h3c);
    poll(aspt_pkg::OFF_S1, 8'h80);
    wr(aspt_pkg::OFF_DB, 8'hc3);
    wait_got(3);
    `CHK(aspt_remote_i.got[1], 9'h13c)
    `CHK(aspt_remote_i.got[2], 9'h1c3)
    `CHK(aspt_remote_i.bad_stop, 0)
    `CHK(pin_o[0], 1'b0)
    $display("test transmit done");
    `CHK(irq, 1'b0)
    wr(aspt_pkg::OFF_C2, 8'h88);
    `CHK(irq, 1'b1)
    wr(aspt_pkg::OFF_C2, 8'h08);
    wr(aspt_pkg::OFF_IMSK, 8'h01);
    `CHK(irq, 1'b1)
    wr(aspt_pkg::OFF_IST, 8'h01);
    `CHK(irq, 1'b0)
    wr(aspt_pkg::OFF_DB, 8'h55);
    poll(aspt_pkg::OFF_IST, 8'h01);
    `CHK(irq, 1'b1)
    wait_got(4);
    wr(aspt_pkg::OFF_IMSK, 8'h00);
    $display("test interrupt done");
    // ****
    // Receive
    // ****
    wr(aspt_pkg::OFF_C1, 8'h40);
    inv <= 1'b0;
    nine <= 1'b0;
    aspt_remote_i.send(8'h77, 1'b1);
    repeat (20) @(posedge clk);
    rd(aspt_pkg::OFF_S1);
    `CHK(v & 8'h20, 8'h00)
    wr(aspt_pkg::OFF_C2, 8'h0c);
    aspt_remote_i.send(8'h5a, 1'b1);
    repeat (20) @(posedge clk);
    rd(aspt_pkg::OFF_S1);
    `CHK(v & 8'h2a, 8'h20)
    rd(aspt_pkg::OFF_DB);
    `CHK(v, 8'h5a)
    aspt_remote_i.send(8'h11, 1'b1);
    aspt_remote_i.send(8'h22, 1'b1);
    repeat (20) @(posedge clk);
    rd(aspt_pkg::OFF_S1);
    `CHK(v & 8'h28, 8'h28)
    rd(aspt_pkg::OFF_DB);
    `CHK(v, 8'h11)
    aspt_remote_i.send(8'h00, 1'b0);
    repeat (20) @(posedge clk);
    rd(aspt_pkg::OFF_S2);
    `CHK(v, 8'h02)
    rd(aspt_pkg::OFF_S1);
    `CHK(v & 8'h22, 8'h22)
    wr(aspt_pkg::OFF_C1, 8'h00);
    `CHK(pin_oe, 2'b10)
    $display("test receive done");
    finish_test();
  end
endmodule : tb_aspt_top
`default_nettype wire
